// file: verilog/aoc_pkg.sv
package aoc_pkg;
    // register indices within the analog output page
    localparam logic [7:0] ADDR_GAIN_SEL    = 8'h02;
    localparam logic [7:0] ADDR_MUTE_FOLLOW = 8'h06;
    localparam logic [7:0] ADDR_BOOST       = 8'h07;
    localparam logic [7:0] ADDR_REF_PIN     = 8'h09;

    // field positions
    localparam int LEFT_BIT     = 4;
    localparam int RIGHT_BIT    = 0;
    localparam int FOLLOW_BIT   = 0;
    localparam int DEEMPH_BIT   = 1;
    localparam int REF_PD_BIT   = 0;

    // reset values, reserved bits included
    localparam logic [7:0] RST_GAIN_SEL    = 8'h00;
    localparam logic [7:0] RST_MUTE_FOLLOW = 8'h01;
    localparam logic [7:0] RST_BOOST       = 8'h00;
    localparam logic [7:0] RST_REF_PIN     = 8'h01;

    // value read back for an unmapped index
    localparam logic [7:0] RD_UNMAPPED     = 8'h00;

    // synchroniser depth for the shared pin
    localparam int SYNC_STAGES = 2;
endpackage : aoc_pkg

// file: verilog/aoc_sync_if.sv
`timescale 1ns/1ns
// carries the resynchronised shared pin level from the synchroniser to the bank
interface aoc_sync_if;
    logic pin_level;

    modport source (output pin_level);
    modport sink   (input  pin_level);
endinterface : aoc_sync_if

// file: verilog/aoc_pin_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for the shared de-emphasis/reference pin
module aoc_pin_sync (
    input  wire logic    ref_clk,
    input  wire logic    rst_n,
    input  wire logic    pin_async,
    aoc_sync_if.source   sync_out
);
    logic [aoc_pkg::SYNC_STAGES-1:0] stage;
    logic [aoc_pkg::SYNC_STAGES-1:0] next_stage;

    // shift in the raw pin; only stage 1 is read outside this chain
    always_comb begin
        next_stage = {stage[aoc_pkg::SYNC_STAGES-2:0], pin_async};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    assign sync_out.pin_level = stage[aoc_pkg::SYNC_STAGES-1];
endmodule : aoc_pin_sync

// file: verilog/aoc_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1: left attenuation select at bit 4 gives 0 dB when clear and -6 dB when set, reset clear.
// R2: right attenuation select at bit 0 gives 0 dB when clear and -6 dB when set, reset clear.
// R3: with mute follow enabled analog mute tracks digital mute, otherwise it never does; resets on.
// R4: left amplitude boost at bit 4 selects normal or +10% (+0.8 dB) amplitude, reset normal.
// R5: right amplitude boost at bit 0 selects normal or +10% amplitude, reset normal.
// R6: pin de-emphasis select at bit 1 routes the shared pin to de-emphasis, else the pin is ignored.
// R7: reference powerdown at bit 0 powers the common-mode reference down when set; resets set.
// R8: reserved bits reset to zero, are stored and read back, and steer nothing.
module aoc_regs (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic       digital_mute,
    input  wire logic       shared_deemph_ref_pin,
    output logic            left_attenuation_sel,
    output logic            right_attenuation_sel,
    output logic            left_amplitude_boost,
    output logic            right_amplitude_boost,
    output logic            analog_mute,
    output logic            deemphasis_ctrl,
    output logic            reference_powerdown
);
    logic [7:0] gain_sel;
    logic [7:0] mute_follow;
    logic [7:0] boost;
    logic [7:0] ref_pin;
    logic [7:0] next_gain_sel;
    logic [7:0] next_mute_follow;
    logic [7:0] next_boost;
    logic [7:0] next_ref_pin;
    logic [7:0] next_rdata;
    logic       next_rvalid;
    logic       next_analog_mute;
    logic       next_deemph;

    aoc_sync_if pin_if ();

    // the pin comes from off chip, so it is resynchronised before any use
    aoc_pin_sync u_sync (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .pin_async (shared_deemph_ref_pin),
        .sync_out  (pin_if.source)
    );

    // read mux shared by the read path; unmapped indices answer zero
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input logic [7:0] g,
        input logic [7:0] m,
        input logic [7:0] b,
        input logic [7:0] r
    );
        logic [7:0] v;
        v = aoc_pkg::RD_UNMAPPED;
        case (addr)
            aoc_pkg::ADDR_GAIN_SEL:    v = g;
            aoc_pkg::ADDR_MUTE_FOLLOW: v = m;
            aoc_pkg::ADDR_BOOST:       v = b;
            aoc_pkg::ADDR_REF_PIN:     v = r;
            default:                   v = aoc_pkg::RD_UNMAPPED;
        endcase
        return v;
    endfunction : read_mux

    // register writes: whole bytes stored, reserved bits kept but unused
    always_comb begin
        next_gain_sel    = gain_sel;
        next_mute_follow = mute_follow;
        next_boost       = boost;
        next_ref_pin     = ref_pin;
        if (reg_wr) begin
            case (reg_addr)
                aoc_pkg::ADDR_GAIN_SEL:    next_gain_sel    = reg_wdata; // see R1 R2 R8
                aoc_pkg::ADDR_MUTE_FOLLOW: next_mute_follow = reg_wdata; // see R3 R8
                aoc_pkg::ADDR_BOOST:       next_boost       = reg_wdata; // see R4 R5 R8
                aoc_pkg::ADDR_REF_PIN:     next_ref_pin     = reg_wdata; // see R6 R7 R8
                default:                   next_gain_sel    = gain_sel;  // writes elsewhere dropped
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_sel    <= aoc_pkg::RST_GAIN_SEL;    // see R1 R2
            mute_follow <= aoc_pkg::RST_MUTE_FOLLOW; // see R3
            boost       <= aoc_pkg::RST_BOOST;       // see R4 R5
            ref_pin     <= aoc_pkg::RST_REF_PIN;     // see R6 R7
        end else begin
            gain_sel    <= next_gain_sel;
            mute_follow <= next_mute_follow;
            boost       <= next_boost;
            ref_pin     <= next_ref_pin;
        end
    end

    // read path: data registered one cycle after the strobe
    always_comb begin
        next_rvalid = reg_rd;
        next_rdata  = reg_rd ? read_mux(reg_addr, gain_sel, mute_follow, boost, ref_pin)
                             : reg_rdata;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // derived controls; registered so the analog side sees glitch-free levels
    always_comb begin
        next_analog_mute = digital_mute & mute_follow[aoc_pkg::FOLLOW_BIT]; // see R3
        next_deemph      = pin_if.pin_level & ref_pin[aoc_pkg::DEEMPH_BIT]; // see R6
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_mute     <= 1'b0;
            deemphasis_ctrl <= 1'b0;
        end else begin
            analog_mute     <= next_analog_mute;
            deemphasis_ctrl <= next_deemph;
        end
    end

    // static fields go straight out of their storage flops
    assign left_attenuation_sel  = gain_sel[aoc_pkg::LEFT_BIT];    // see R1
    assign right_attenuation_sel = gain_sel[aoc_pkg::RIGHT_BIT];   // see R2
    assign left_amplitude_boost  = boost[aoc_pkg::LEFT_BIT];       // see R4
    assign right_amplitude_boost = boost[aoc_pkg::RIGHT_BIT];      // see R5
    assign reference_powerdown   = ref_pin[aoc_pkg::REF_PD_BIT];   // see R7

    // checks on the outputs that software and the analog side rely on
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    left_atten_a: assert property ( // see R1
        reg_wr && reg_addr == aoc_pkg::ADDR_GAIN_SEL
        |=> left_attenuation_sel == $past(reg_wdata[4]))
        else $error("left attenuation did not follow write");

    right_atten_a: assert property ( // see R2
        reg_wr && reg_addr == aoc_pkg::ADDR_GAIN_SEL
        |=> right_attenuation_sel == $past(reg_wdata[0]))
        else $error("right attenuation did not follow write");

    mute_follow_a: assert property ( // see R3
        ##1 analog_mute == ($past(digital_mute) && $past(mute_follow[0])))
        else $error("analog mute not tied to digital mute and enable");

    left_boost_a: assert property ( // see R4
        reg_wr && reg_addr == aoc_pkg::ADDR_BOOST
        |=> left_amplitude_boost == $past(reg_wdata[4]) && boost == $past(reg_wdata))
        else $error("left boost did not follow write");

    right_boost_a: assert property ( // see R5
        !(reg_wr && reg_addr == aoc_pkg::ADDR_BOOST) |=> $stable(right_amplitude_boost))
        else $error("right boost changed without a write");

    // the right bit must land on the write, not only hold between writes
    right_boost_wr_a: assert property ( // see R5
        reg_wr && reg_addr == aoc_pkg::ADDR_BOOST
        |=> right_amplitude_boost == $past(reg_wdata[0]))
        else $error("right boost did not follow write");

    deemph_gate_a: assert property ( // see R6
        (!ref_pin[aoc_pkg::DEEMPH_BIT]) [*2] |-> !deemphasis_ctrl)
        else $error("de-emphasis driven while pin use disabled");

    // with the pin selected the control is the resynchronised level, one edge late
    deemph_pass_a: assert property ( // see R6
        (ref_pin[aoc_pkg::DEEMPH_BIT]) [*2] |-> deemphasis_ctrl == $past(pin_if.pin_level))
        else $error("de-emphasis does not track the pin");

    ref_pd_a: assert property ( // see R7
        reg_wr && reg_addr == aoc_pkg::ADDR_REF_PIN
        |=> reference_powerdown == $past(reg_wdata[0]))
        else $error("reference powerdown did not follow write");

    reserved_rb_a: assert property ( // see R8
        reg_rd && !reg_wr && reg_addr == aoc_pkg::ADDR_GAIN_SEL
        |=> reg_rvalid && reg_rdata == $past(gain_sel))
        else $error("stored byte not read back whole");

    // reserved bits ride along with the fields, so the whole byte must land
    gain_store_a: assert property ( // see R8
        reg_wr && reg_addr == aoc_pkg::ADDR_GAIN_SEL |=> gain_sel == $past(reg_wdata))
        else $error("gain byte not stored whole");

    ref_store_a: assert property ( // see R8
        reg_wr && reg_addr == aoc_pkg::ADDR_REF_PIN |=> ref_pin == $past(reg_wdata))
        else $error("reference byte not stored whole");

    unmapped_rd_a: assert property ( // see R8
        reg_rd && reg_addr == 8'h03 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // a write to a hole in the map must leave every stored byte alone
    unmapped_wr_a: assert property ( // see R8
        reg_wr && reg_addr == 8'h03
        |=> $stable(gain_sel) && $stable(mute_follow) && $stable(boost) && $stable(ref_pin))
        else $error("unmapped write changed a register");

    // software takes the answer on the very next edge, so a late answer is a fault
    rvalid_pulse_a: assert property ( // see R8
        reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after strobe");

    readback_cv: cover property (reg_rd ##1 reg_rvalid);
    mute_cv: cover property (mute_follow[0] && digital_mute ##1 analog_mute);
    nofollow_cv: cover property (!mute_follow[0] && digital_mute ##1 !analog_mute);
    deemph_cv: cover property (ref_pin[1] ##1 deemphasis_ctrl);
    ref_on_cv: cover property ($fell(reference_powerdown));
endmodule : aoc_regs

// file: dv/aoc_host.sv
`timescale 1ns/1ns
// host side of the control port: one byte per strobe, driven just after an edge
module aoc_host (
    input  wire logic       ref_clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // idle bus before the first access
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // released lines flip so a stale value never looks valid
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : write_byte

    // hung stays set when no answer arrives within a few cycles
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output bit hung);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        hung = 1'b1;
        d = 8'h00;
        for (int i = 0; i < 4 && hung; i++) begin
            #1;
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                hung = 1'b0;
            end else begin
                @(posedge ref_clk);
            end
        end
    endtask : read_byte
endmodule : aoc_host

// file: dv/tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the analog output control bank
module tb_top;
    logic       ref_clk;
    logic       rst_n;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       digital_mute;
    logic       pin;
    wire  [7:0] fields;
    int         errors;
    int         samples_checked;

    aoc_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .digital_mute(digital_mute), .shared_deemph_ref_pin(pin),
        .left_attenuation_sel(fields[6]), .right_attenuation_sel(fields[5]),
        .left_amplitude_boost(fields[4]), .right_amplitude_boost(fields[3]),
        .analog_mute(fields[2]), .deemphasis_ctrl(fields[1]),
        .reference_powerdown(fields[0]));
    aoc_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    assign fields[7] = 1'b0;

    // 100 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run;
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // a read with no answer ends the run at once
    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit         hung;
        host.read_byte(a, d, hung);
        if (hung) begin
            errors++;
            complete_run();
        end else begin
            check(d, exp);
        end
    endtask : read_check

    // outputs follow a write on the edge that takes it, mute one edge later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_byte(a, d);
        @(posedge ref_clk);
        #1;
    endtask : wr

    initial begin
        rst_n = 1'b0;
        digital_mute = 1'b0;
        pin = 1'b1;
        errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check(fields, 8'h01);
        read_check(aoc_pkg::ADDR_GAIN_SEL, 8'h00);
        read_check(aoc_pkg::ADDR_MUTE_FOLLOW, 8'h01);
        read_check(aoc_pkg::ADDR_BOOST, 8'h00);
        read_check(aoc_pkg::ADDR_REF_PIN, 8'h01);
        wr(aoc_pkg::ADDR_GAIN_SEL, 8'h10);
        check(fields, 8'h41);
        wr(aoc_pkg::ADDR_GAIN_SEL, 8'h01);
        check(fields, 8'h21);
        wr(aoc_pkg::ADDR_GAIN_SEL, 8'hee);
        check(fields, 8'h01);
        read_check(aoc_pkg::ADDR_GAIN_SEL, 8'hee);
        wr(aoc_pkg::ADDR_BOOST, 8'h11);
        check(fields, 8'h19);
        read_check(aoc_pkg::ADDR_BOOST, 8'h11);
        @(posedge ref_clk);
        digital_mute <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check(fields, 8'h1d);
        wr(aoc_pkg::ADDR_MUTE_FOLLOW, 8'h00);
        check(fields, 8'h19);
        // pin is high, so de-emphasis shows only once selected
        wr(aoc_pkg::ADDR_REF_PIN, 8'h02);
        repeat (3) @(posedge ref_clk);
        #1;
        check(fields, 8'h1a);
        // a pin change crosses two synchroniser stages and the output flop
        @(posedge ref_clk);
        pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check(fields, 8'h18);
        @(posedge ref_clk);
        pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check(fields, 8'h1a);
        wr(aoc_pkg::ADDR_REF_PIN, 8'hfd);
        check(fields, 8'h19);
        read_check(aoc_pkg::ADDR_REF_PIN, 8'hfd);
        wr(8'h03, 8'h5a);
        read_check(8'h03, 8'h00);
        read_check(aoc_pkg::ADDR_GAIN_SEL, 8'hee);
        check(fields, 8'h19);
        complete_run();
    end

    // guard against a hang anywhere in the sequence
    initial begin
        repeat (2000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
endmodule : tb_top
